// >>> ocb_ctrl.sv
// Notes on behaviour
// RULE1 - mode bits 2:1 pick drive: 00 is 14 mA, 01 21 mA, 10 28 mA.
// RULE2 - mode 11 powers the driver down and floats both pair outputs.
// RULE3 - mode 01 is the middle amplitude between lowest and highest drive.
// RULE4 - bit 0 low gives normal polarity, high inverts the output clock.
// RULE5 - after reset: 14 mA drive and normal polarity.
// RULE6 - channel divider divides its input by the 10-bit value plus one.
// RULE7 - divide value low byte at 0x043c, top two bits at 0x043d bits 1:0.
// RULE8 - divide value low byte resets to zero.
// RULE9 - after sync the divider starts at a 6-bit initial phase.
// RULE10 - one phase step is half an input period; zero means none; resets 0.
// RULE11 - reserved bits read zero and ignore writes.
// RULE12 - new divide value or phase takes effect at the next sync.
`timescale 1ns/1ps
`include "ocb_params.svh"
module ocb_ctrl (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire ocb_pkg::ocb_addr_t reg_addr,
  input wire ocb_pkg::ocb_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ocb_pkg::ocb_byte_t reg_rdata,
  input wire logic prescaler_clk,
  input wire logic sync_evt,
  output ocb_pkg::ocb_drive_e drive_select,
  output logic driver_pwdn,
  output logic out_p,
  output logic out_n,
  output logic out_oe
);
  import ocb_pkg::*;

  ocb_byte_t settings_reg;
  ocb_byte_t div_lo_reg;
  ocb_byte_t div_hi_reg;
  ocb_byte_t phase_reg;
  ocb_byte_t rdata_reg;
  ocb_byte_t rdata_next;
  logic presc_prev_reg;
  logic out_p_reg;
  logic out_n_reg;
  logic out_oe_reg;
  ocb_drive_e drive_reg;
  logic pwdn_reg;
  ocb_drive_e mode_w;
  logic inv_w;

  ocb_div_if div_bus ();

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      settings_reg <= `OCB_SET_RST; // RULE5
    end else if (clk_en && reg_wr && reg_addr == `OCB_OFS_SETTINGS) begin
      settings_reg <= reg_wdata & `OCB_SET_MASK; // RULE11
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_lo_reg <= `OCB_DIV_LO_RST; // RULE8
    end else if (clk_en && reg_wr && reg_addr == `OCB_OFS_DIV_LO) begin
      div_lo_reg <= reg_wdata; // RULE7
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_hi_reg <= `OCB_DIV_HI_RST;
    end else if (clk_en && reg_wr && reg_addr == `OCB_OFS_DIV_HI) begin
      div_hi_reg <= reg_wdata & `OCB_DIV_HI_MASK; // RULE7 RULE11
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= `OCB_PHASE_RST; // RULE10
    end else if (clk_en && reg_wr && reg_addr == `OCB_OFS_PHASE) begin
      phase_reg <= reg_wdata & `OCB_PHASE_MASK; // RULE11
    end
  end

  // ************************************************************
  // register reads, data one cycle after the strobe
  // ************************************************************
  always_comb begin
    rdata_next = `OCB_BYTE_ZERO;
    case (reg_addr)
      `OCB_OFS_SETTINGS: rdata_next = settings_reg;
      `OCB_OFS_DIV_LO: rdata_next = div_lo_reg;
      `OCB_OFS_DIV_HI: rdata_next = div_hi_reg;
      `OCB_OFS_PHASE: rdata_next = phase_reg;
      `OCB_OFS_STATUS: rdata_next = {4'h0, div_bus.clk_out, div_bus.state};
      default: rdata_next = `OCB_BYTE_ZERO;
    endcase
  end

  // read data stand one cycle per enabled read strobe and hold while clk_en is low, zero otherwise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= `OCB_BYTE_ZERO;
    end else if (clk_en) begin
      rdata_reg <= reg_rd ? rdata_next : `OCB_BYTE_ZERO;
    end
  end

  assign reg_rdata = rdata_reg;

  // ************************************************************
  // divider input: each prescaler edge is half a period
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_prev_reg <= 1'b0;
    end else if (clk_en) begin
      presc_prev_reg <= prescaler_clk;
    end
  end

  // limitation: prescaler must not exceed half of sys_clk
  assign div_bus.half_tick = prescaler_clk ^ presc_prev_reg; // RULE10
  assign div_bus.sync = sync_evt;
  assign div_bus.div_value = {div_hi_reg[1:0], div_lo_reg}; // RULE7
  assign div_bus.phase = phase_reg[5:0]; // RULE9

  ocb_divider u_divider (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .bus(div_bus.div)
  );

  // ************************************************************
  // output driver control
  // ************************************************************
  assign mode_w = ocb_drive_e'(settings_reg[`OCB_MODE_MSB:`OCB_MODE_LSB]);
  assign inv_w = settings_reg[`OCB_INV_BIT];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_reg <= OCB_DRIVE_14MA; // RULE5
      pwdn_reg <= 1'b0;
    end else if (clk_en) begin
      case (mode_w) // RULE1
        OCB_DRIVE_14MA: drive_reg <= OCB_DRIVE_14MA;
        OCB_DRIVE_21MA: drive_reg <= OCB_DRIVE_21MA; // RULE3
        OCB_DRIVE_28MA: drive_reg <= OCB_DRIVE_28MA;
        default: drive_reg <= OCB_DRIVE_OFF;
      endcase
      pwdn_reg <= (mode_w == `OCB_MODE_PWDN); // RULE2
    end
  end

  // registered pair keeps both legs aligned to one edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_p_reg <= 1'b0;
      out_n_reg <= 1'b1;
      out_oe_reg <= 1'b1;
    end else if (clk_en) begin
      out_p_reg <= div_bus.clk_out ^ inv_w; // RULE4
      out_n_reg <= ~(div_bus.clk_out ^ inv_w); // RULE4
      out_oe_reg <= (mode_w != `OCB_MODE_PWDN); // RULE2
    end
  end

  assign drive_select = drive_reg;
  assign driver_pwdn = pwdn_reg;
  assign out_p = out_p_reg;
  assign out_n = out_n_reg;
  assign out_oe = out_oe_reg;
endmodule

// >>> ocb_params.svh
`ifndef OCB_PARAMS_SVH
`define OCB_PARAMS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define OCB_ADDR_W 16
`define OCB_OFS_SETTINGS 16'h043b
`define OCB_OFS_DIV_LO 16'h043c
`define OCB_OFS_DIV_HI 16'h043d
`define OCB_OFS_PHASE 16'h043e
`define OCB_OFS_STATUS 16'h04f0

// ************************************************************
// field layout and reset values
// ************************************************************
`define OCB_INV_BIT 0
`define OCB_MODE_LSB 1
`define OCB_MODE_MSB 2
`define OCB_SET_MASK 8'h07
`define OCB_DIV_HI_MASK 8'h03
`define OCB_PHASE_MASK 8'h3f
`define OCB_SET_RST 8'h00
`define OCB_DIV_LO_RST 8'h00
`define OCB_DIV_HI_RST 8'h00
`define OCB_PHASE_RST 8'h00
`define OCB_MODE_PWDN 2'h3
`define OCB_DIV_W 10
`define OCB_PHASE_W 6
`define OCB_DIV_ZERO 10'h000
`define OCB_PHASE_ZERO 6'h00
`define OCB_BYTE_ZERO 8'h00
`define OCB_PHASE_STEP 6'h01
`define OCB_DIV_STEP 10'h001

`endif

// >>> ocb_pkg.sv
package ocb_pkg;
  typedef logic [15:0] ocb_addr_t;
  typedef logic [7:0] ocb_byte_t;
  typedef logic [9:0] ocb_div_t;
  typedef logic [5:0] ocb_phase_t;

  typedef enum logic [1:0] {
    OCB_DRIVE_14MA = 2'h0,
    OCB_DRIVE_21MA = 2'h1,
    OCB_DRIVE_28MA = 2'h2,
    OCB_DRIVE_OFF = 2'h3
  } ocb_drive_e;

  typedef enum logic [2:0] {
    OCB_ST_HOLD = 3'b001,
    OCB_ST_PHASE = 3'b010,
    OCB_ST_RUN = 3'b100
  } ocb_state_e;
endpackage

// >>> ocb_div_if.sv
`timescale 1ns/1ps
interface ocb_div_if;
  import ocb_pkg::*;
  ocb_div_t div_value;
  ocb_phase_t phase;
  logic sync;
  logic half_tick;
  logic clk_out;
  ocb_state_e state;

  modport ctrl (
    output div_value,
    output phase,
    output sync,
    output half_tick,
    input clk_out,
    input state
  );
  modport div (
    input div_value,
    input phase,
    input sync,
    input half_tick,
    output clk_out,
    output state
  );
endinterface

// >>> ocb_divider.sv
`timescale 1ns/1ps
`include "ocb_params.svh"
module ocb_divider (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  ocb_div_if.div bus
);
  import ocb_pkg::*;

  ocb_state_e state_reg;
  ocb_div_t div_reg;
  ocb_div_t cnt_reg;
  ocb_phase_t ph_cnt_reg;
  logic out_reg;

  assign bus.clk_out = out_reg;
  assign bus.state = state_reg;

  // ************************************************************
  // settings captured only at sync, never mid-period
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= `OCB_DIV_ZERO;
    end else if (clk_en && bus.sync) begin
      div_reg <= bus.div_value; // RULE12
    end
  end

  // ************************************************************
  // state and phase delay
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= OCB_ST_HOLD;
      ph_cnt_reg <= `OCB_PHASE_ZERO;
    end else if (clk_en) begin
      if (bus.sync) begin
        ph_cnt_reg <= bus.phase; // RULE9
        // zero phase starts at once, no offset
        if (bus.phase == `OCB_PHASE_ZERO) begin // RULE10
          state_reg <= OCB_ST_RUN;
        end else begin
          state_reg <= OCB_ST_PHASE;
        end
      end else begin
        case (state_reg)
          OCB_ST_HOLD: begin
            state_reg <= OCB_ST_HOLD;
          end
          OCB_ST_PHASE: begin
            // each tick is half an input period
            if (bus.half_tick) begin // RULE10
              ph_cnt_reg <= ph_cnt_reg - `OCB_PHASE_STEP;
              if (ph_cnt_reg == `OCB_PHASE_STEP) begin
                state_reg <= OCB_ST_RUN;
              end
            end
          end
          OCB_ST_RUN: begin
            state_reg <= OCB_ST_RUN;
          end
          default: begin
            state_reg <= OCB_ST_HOLD;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // divide by value + 1: toggle every value + 1 half periods
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= `OCB_DIV_ZERO;
      out_reg <= 1'b0;
    end else if (clk_en) begin
      if (bus.sync) begin
        cnt_reg <= `OCB_DIV_ZERO;
        out_reg <= 1'b0;
      end else if (state_reg == OCB_ST_RUN && bus.half_tick) begin
        if (cnt_reg == div_reg) begin // RULE6
          cnt_reg <= `OCB_DIV_ZERO;
          out_reg <= ~out_reg;
        end else begin
          cnt_reg <= cnt_reg + `OCB_DIV_STEP;
        end
      end
    end
  end
endmodule

// >>> ocb_ctrl_props.sv
`timescale 1ns/1ps
module ocb_ctrl_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire ocb_pkg::ocb_addr_t reg_addr,
  input wire ocb_pkg::ocb_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ocb_pkg::ocb_byte_t reg_rdata,
  input wire logic prescaler_clk,
  input wire logic sync_evt,
  input wire ocb_pkg::ocb_drive_e drive_select,
  input wire logic driver_pwdn,
  input wire logic out_p,
  input wire logic out_n,
  input wire logic out_oe
);
  import ocb_pkg::*;
  // ****************
  // port checks
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_set_wr;
    reg_wr && clk_en && reg_addr == 16'h043b;
  endsequence
  sequence s_rd(a);
    reg_rd && clk_en && reg_addr == a;
  endsequence
  a_legs_opposite: assert property (out_n == !out_p)
    else $error("output legs not complementary");
  a_pwdn_tristate: assert property (
    driver_pwdn == (drive_select == OCB_DRIVE_OFF) && out_oe == !driver_pwdn)
    else $error("power down or enable disagrees with mode");
  a_mode_follows: assert property (
    s_set_wr ##1 (clk_en && !reg_wr) |=>
    drive_select == $past(reg_wdata[2:1], 2))
    else $error("drive code does not follow written mode");
  // clk_en low would delay the update, so only judged when running
  a_drive_by_write: assert property (
    $changed(drive_select) && $past(clk_en) && $past(clk_en, 2)
    |-> $past(reg_wr, 2))
    else $error("drive code changed without a write");
  a_set_rsvd: assert property (
    s_rd(16'h043b) |=> reg_rdata[7:3] == 5'h00)
    else $error("settings reserved bits not zero");
  a_divhi_rsvd: assert property (
    s_rd(16'h043d) |=> reg_rdata[7:2] == 6'h00)
    else $error("divider high reserved bits not zero");
  a_phase_rsvd: assert property (
    s_rd(16'h043e) |=> reg_rdata[7:6] == 2'h0)
    else $error("phase reserved bits not zero");
  a_reset_state: assert property (
    $rose(arst_n) |-> drive_select == OCB_DRIVE_14MA && !driver_pwdn && out_oe)
    else $error("outputs not at reset settings");
endmodule

bind ocb_ctrl ocb_ctrl_props i_props (.sys_clk(sys_clk), .arst_n(arst_n),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .prescaler_clk(prescaler_clk), .sync_evt(sync_evt),
  .drive_select(drive_select), .driver_pwdn(driver_pwdn),
  .out_p(out_p), .out_n(out_n), .out_oe(out_oe));

// >>> ocb_rx_model.sv
`timescale 1ns/1ps
module ocb_rx_model (
  input wire logic sys_clk,
  input wire logic out_p,
  input wire logic out_n,
  input wire logic out_oe,
  output logic rx_p,
  output logic [15:0] period,
  output logic [15:0] rises
);
  // ****************
  // differential receiver
  // ****************
  logic [15:0] cnt = 16'h0000;
  logic prev = 1'b0;
  // a tristated pair floats, so the receiver sees no level at all
  assign rx_p = out_oe ? (out_p & ~out_n) : 1'bz;
  initial begin
    period = 16'h0000;
    rises = 16'h0000;
  end
  always @(posedge sys_clk) begin
    cnt <= cnt + 16'h0001;
    prev <= rx_p;
    if (rx_p === 1'b1 && prev === 1'b0) begin
      period <= cnt;
      cnt <= 16'h0001;
      rises <= rises + 16'h0001;
    end
  end
endmodule

// >>> output_channel_b_divider_ctrl_test.sv
`timescale 1ns/1ps
module output_channel_b_divider_ctrl_test;
  import ocb_pkg::*;
  // ****************
  // bench
  // ****************
  logic sys_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, psc_run = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, prescaler_clk = 1'b0, sync_evt = 1'b0;
  ocb_addr_t reg_addr = 16'h0000;
  ocb_byte_t reg_wdata = 8'h00;
  ocb_byte_t reg_rdata;
  ocb_drive_e drive_select;
  logic driver_pwdn, out_p, out_n, out_oe, rx_p;
  logic [15:0] period, rises;
  int n_fail = 0, checked = 0, lat0 = 0;
  ocb_ctrl i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prescaler_clk(prescaler_clk),
    .sync_evt(sync_evt), .drive_select(drive_select),
    .driver_pwdn(driver_pwdn), .out_p(out_p), .out_n(out_n), .out_oe(out_oe));
  ocb_rx_model i_rx (.sys_clk(sys_clk), .out_p(out_p), .out_n(out_n),
    .out_oe(out_oe), .rx_p(rx_p), .period(period), .rises(rises));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // fastest prescaler: one half period per system cycle
  always @(posedge sys_clk) begin
    if (psc_run) prescaler_clk <= ~prescaler_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input ocb_addr_t a, input ocb_byte_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input ocb_addr_t a, input ocb_byte_t e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic sync_now();
    @(posedge sys_clk);
    sync_evt <= 1'b1;
    @(posedge sys_clk);
    sync_evt <= 1'b0;
  endtask
  task automatic wait_rises(input int n);
    logic [15:0] goal;
    goal = rises + 16'(n);
    for (int i = 0; i < 9000 && rises < goal; i++) @(posedge sys_clk);
    if (rises < goal) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic t_reset_values();
    chk({15'h0, out_p}, 16'h0000);
    rd(16'h043b, 8'h00);
    rd(16'h043c, 8'h00);
    rd(16'h043e, 8'h00);
    rd(16'h04f0, 8'h01);
  endtask
  // clock enable low: the write must be lost
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(16'h043b, 8'h02);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(16'h043b, 8'h00);
    chk({14'h0, drive_select}, 16'h0000);
  endtask
  task automatic t_reserved();
    wr(16'h043b, 8'hf8);
    rd(16'h043b, 8'h00);
    wr(16'h043d, 8'hff);
    rd(16'h043d, 8'h03);
    wr(16'h043e, 8'hff);
    rd(16'h043e, 8'h3f);
    wr(16'h0440, 8'hff);
    rd(16'h0440, 8'h00);
    wr(16'h043d, 8'h00);
    wr(16'h043e, 8'h00);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(16'h043b, 8'(m << 1));
      @(posedge sys_clk);
      #1 chk({14'h0, drive_select}, 16'(m));
      chk({15'h0, out_oe}, {15'h0, m != 3});
      chk({15'h0, driver_pwdn}, {15'h0, m == 3});
      if (m == 3) chk({15'h0, rx_p}, {15'h0, 1'bz});
    end
    wr(16'h043b, 8'h00);
  endtask
  task automatic t_polarity();
    wr(16'h043b, 8'h01);
    sync_now();
    repeat (3) @(posedge sys_clk);
    #1 chk({14'h0, out_p, out_n}, 16'h0002);
    wr(16'h043b, 8'h00);
    sync_now();
    repeat (3) @(posedge sys_clk);
    #1 chk({14'h0, out_p, out_n}, 16'h0001);
    rd(16'h04f0, 8'h04);
  endtask
  task automatic t_divide();
    logic [9:0] n;
    psc_run <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 10'h000 : (k == 1) ? 10'h002 : 10'h3ff;
      wr(16'h043c, n[7:0]);
      wr(16'h043d, {6'h00, n[9:8]});
      sync_now();
      wait_rises(3);
      chk(period, 16'(2 * (n + 1)));
    end
  endtask
  task automatic t_late_change();
    wr(16'h043c, 8'h02);
    wr(16'h043d, 8'h00);
    sync_now();
    wait_rises(3);
    wr(16'h043c, 8'h05);
    wait_rises(2);
    chk(period, 16'h0006);
    sync_now();
    wait_rises(3);
    chk(period, 16'h000c);
  endtask
  // prescaler held during sync so both runs start from the same point
  task automatic t_phase();
    int lat;
    wr(16'h043c, 8'h00);
    for (int p = 0; p < 4; p += 3) begin
      psc_run <= 1'b0;
      wr(16'h043e, 8'(p));
      sync_now();
      repeat (4) @(posedge sys_clk);
      psc_run <= 1'b1;
      lat = 0;
      #1;
      for (int i = 0; i < 200 && rx_p !== 1'b1; i++) begin
        @(posedge sys_clk);
        #1 lat++;
      end
      if (p == 0) lat0 = lat;
      else chk(16'(lat - lat0), 16'h0003);
    end
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset_values();
    t_reserved();
    t_modes();
    t_freeze();
    t_polarity();
    t_divide();
    t_late_change();
    t_phase();
    wrap_up();
  end
endmodule
